// [bench/crs_core_test.sv]
// crs_core_test: self-checking bench for the return, sleep and alu execution block
`timescale 1ns/1ns
module crs_core_test;
	logic        clock = 1'b0;     // 10 MHz instruction clock
	logic        rst = 1'b1;       // synchronous reset
	logic        op_valid = 1'b0;  // op presented
	logic [3:0]  op = 4'h0;        // operation code
	logic [7:0]  literal = 8'h00;  // literal operand
	logic [6:0]  file_addr = 7'h00; // file address
	logic        dest_sel = 1'b0;  // destination select
	logic [7:0]  file_rdata = 8'h00; // file read value
	logic        push_valid = 1'b0; // call push strobe
	logic [12:0] push_pc = 13'h0000; // pushed return address
	logic        wake = 1'b0;      // wake-up condition
	logic        busy, carry_flag, half_carry_flag, zero_flag, timeout_flag;
	logic        power_down_flag, file_we, osc_run, fetch_refill;
	logic [7:0]  acc, file_wdata, watchdog_counter, watchdog_prescaler;
	logic [12:0] pc;
	logic [6:0]  file_waddr;
	int          miscompares = 0;
	int          n_tests = 0;

	crs_core i_crs_core (.clock(clock), .rst(rst), .op_valid(op_valid), .op(op),
		.literal(literal), .file_addr(file_addr), .dest_sel(dest_sel),
		.file_rdata(file_rdata), .push_valid(push_valid), .push_pc(push_pc), .wake(wake),
		.busy(busy), .acc(acc), .pc(pc), .carry_flag(carry_flag),
		.half_carry_flag(half_carry_flag), .zero_flag(zero_flag), .timeout_flag(timeout_flag),
		.power_down_flag(power_down_flag), .file_we(file_we), .file_waddr(file_waddr),
		.file_wdata(file_wdata), .watchdog_counter(watchdog_counter),
		.watchdog_prescaler(watchdog_prescaler), .osc_run(osc_run), .fetch_refill(fetch_refill));

	// half period of 50 ns gives the 100 ns cycle
	always #50 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic summarize();
		if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one op, taken at the second edge; results are looked at just after it
	task automatic do_op(input logic [3:0] o, input logic [7:0] k, input logic [6:0] a,
			input logic d, input logic [7:0] f);
		@(posedge clock);
		op_valid   <= 1'b1;
		op         <= o;
		literal    <= k;
		file_addr  <= a;
		dest_sel   <= d;
		file_rdata <= f;
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic chk_alu(input logic [7:0] a, input logic [2:0] fl);
		chk("acc", a, acc);
		chk("flags", fl, {carry_flag, half_carry_flag, zero_flag});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_subtract();
		do_op(crs_pkg::CRS_OP_LSUB, 8'h10, 7'h00, 1'b1, 8'h00);
		chk_alu(8'h10, 3'b110);
		do_op(crs_pkg::CRS_OP_LSUB, 8'h05, 7'h00, 1'b0, 8'h00);
		chk_alu(8'hf5, 3'b010);
		do_op(crs_pkg::CRS_OP_LXOR, 8'hf5, 7'h00, 1'b0, 8'h00);
		chk_alu(8'h00, 3'b011);
		do_op(crs_pkg::CRS_OP_LSUB, 8'h23, 7'h00, 1'b0, 8'h00);
		do_op(crs_pkg::CRS_OP_FSUB, 8'h00, 7'h7f, 1'b1, 8'h12);
		chk_alu(8'h23, 3'b000);
		chk("we", 1'b1, file_we);
		chk("waddr", 7'h7f, file_waddr);
		chk("wdata", 8'hef, file_wdata);
		do_op(crs_pkg::CRS_OP_FSUB, 8'h00, 7'h00, 1'b0, 8'h23);
		chk_alu(8'h00, 3'b111);
		chk("we", 1'b0, file_we);
	endtask

	task automatic t_xor_swap();
		do_op(crs_pkg::CRS_OP_LXOR, 8'h3c, 7'h00, 1'b0, 8'h00);
		do_op(crs_pkg::CRS_OP_FXOR, 8'h00, 7'h01, 1'b1, 8'h3c);
		chk_alu(8'h3c, 3'b111);
		chk("wdata", 8'h00, file_wdata);
		do_op(crs_pkg::CRS_OP_FXOR, 8'h00, 7'h01, 1'b0, 8'hc3);
		chk_alu(8'hff, 3'b110);
		do_op(crs_pkg::CRS_OP_SWAP, 8'h00, 7'h55, 1'b1, 8'ha5);
		chk_alu(8'hff, 3'b110);
		chk("wdata", 8'h5a, file_wdata);
		chk("waddr", 7'h55, file_waddr);
		do_op(crs_pkg::CRS_OP_SWAP, 8'h00, 7'h55, 1'b0, 8'ha5);
		chk_alu(8'h5a, 3'b110);
		// an unused code must leave everything alone
		do_op(4'h9, 8'h11, 7'h02, 1'b1, 8'h77);
		chk_alu(8'h5a, 3'b110);
		chk("we", 1'b0, file_we);
	endtask

	task automatic t_return();
		@(posedge clock);
		push_valid <= 1'b1;
		push_pc <= 13'h0123;
		@(posedge clock);
		push_pc <= 13'h0456;
		@(posedge clock);
		push_valid <= 1'b0;
		op_valid <= 1'b1;
		op <= crs_pkg::CRS_OP_RETURN;
		// an op held up during the refill cycle must be ignored
		@(posedge clock);
		op <= crs_pkg::CRS_OP_LXOR;
		literal <= 8'hff;
		#1;
		chk("pc", 13'h0456, pc);
		chk("busy", 1'b1, busy);
		chk("refill", 1'b1, fetch_refill);
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
		chk("busy", 1'b0, busy);
		chk("refill", 1'b0, fetch_refill);
		chk_alu(8'h5a, 3'b110);
		do_op(crs_pkg::CRS_OP_RETURN, 8'h00, 7'h00, 1'b0, 8'h00);
		chk("pc", 13'h0123, pc);
		@(posedge clock);
	endtask

	task automatic t_sleep();
		// idle past one prescaler wrap so the counter is non-zero before the clear
		repeat (300) @(posedge clock);
		do_op(crs_pkg::CRS_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00);
		chk("tpd", 2'b10, {timeout_flag, power_down_flag});
		chk("watchdog", 8'h00, watchdog_counter);
		chk("pre", 8'h00, watchdog_prescaler);
		chk_alu(8'h5a, 3'b110);
		repeat (3) @(posedge clock);
		#1;
		chk("osc", 1'b0, osc_run);
		chk("busy", 1'b1, busy);
		@(posedge clock);
		wake <= 1'b1;
		@(posedge clock);
		wake <= 1'b0;
		#1;
		chk("osc", 1'b1, osc_run);
		chk("busy", 1'b0, busy);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		#1;
		chk("acc", 8'h00, acc);
		chk("tpd", 2'b11, {timeout_flag, power_down_flag});
		t_subtract();
		t_xor_swap();
		t_return();
		t_sleep();
		summarize();
	end

	// watchdog: the tests need well under 500 cycles
	initial begin
		repeat (2000) @(posedge clock);
		miscompares++;
		summarize();
	end
endmodule // crs_core_test

// [verilog/crs_core.sv]
// crs_core: execution of return, sleep, subtract, xor and nibble exchange
//
// Operation
// - return pops stack into pc, flags kept
// - return takes two cycles, second refills fetch
// - sleep clears power-down, sets timeout flag
// - sleep clears watchdog counter and prescaler
// - sleep halts oscillator until wake-up
// - literal minus accumulator into accumulator, c/hc/z
// - file minus accumulator, address 0..127, c/hc/z
// - destination bit 0 accumulator, 1 file
// - literal xor accumulator, only zero flag
// - file xor accumulator, routed, only zero
// - nibble exchange swaps halves, no flags
// - nibble exchange destination by select bit
`timescale 1ns/1ns
module crs_core #(
	parameter int STACK_DEPTH = crs_pkg::STACK_DEPTH
) (
	input  wire logic                     clock,        // 10 MHz instruction clock
	input  wire logic                     rst,          // synchronous, active high
	input  wire logic                     op_valid,     // op is presented this cycle
	input  wire logic [3:0]               op,           // operation code
	input  wire logic [7:0]               literal,      // 8-bit literal operand
	input  wire logic [6:0]               file_addr,    // file address 0..127
	input  wire logic                     dest_sel,     // 0 accumulator, 1 file
	input  wire logic [7:0]               file_rdata,   // addressed file register value
	input  wire logic                     push_valid,   // call pushes push_pc
	input  wire logic [12:0]              push_pc,      // return address to push
	input  wire logic                     wake,         // wake-up condition
	output logic                          busy,         // op not accepted this cycle
	output logic [7:0]                    acc,          // accumulator
	output logic [12:0]                   pc,           // program counter
	output logic                          carry_flag,   // carry / not-borrow
	output logic                          half_carry_flag, // digit not-borrow
	output logic                          zero_flag,    // zero result
	output logic                          timeout_flag, // time-out status
	output logic                          power_down_flag, // power-down status
	output logic                          file_we,      // file write strobe
	output logic [6:0]                    file_waddr,   // file write address
	output logic [7:0]                    file_wdata,   // file write data
	output logic [7:0]                    watchdog_counter, // watchdog count
	output logic [7:0]                    watchdog_prescaler, // prescaler count
	output logic                          osc_run,      // main oscillator enable
	output logic                          fetch_refill  // refill cycle after return
);
	//////////////////////////////////////////////////////////////////////////////
	// arithmetic helper: a - b with not-borrow at bit 3 and bit 7
	function automatic logic [9:0] sub_nb(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		return {full[8], low[4], full[7:0]};
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// stack; an overflowing push wraps and overwrites the oldest entry
	logic [12:0]        stack_mem [STACK_DEPTH];
	logic [2:0]         sp;
	crs_pkg::crs_state_e state;

	wire               take      = op_valid && (state == crs_pkg::CRS_ST_RUN);
	wire crs_pkg::crs_op_e opc   = crs_pkg::crs_op_e'(op);
	wire [2:0]         sp_top    = sp - 3'h1;
	wire [12:0]        stack_top_entry = stack_mem[sp_top];
	wire               is_ret    = take && opc == crs_pkg::CRS_OP_RETURN;
	wire               is_sleep  = take && opc == crs_pkg::CRS_OP_SLEEP;

	wire [7:0]         sub_a     = (opc == crs_pkg::CRS_OP_LSUB) ? literal : file_rdata;
	wire [9:0]         sub_r     = sub_nb(sub_a, acc);
	wire [7:0]         xor_r     = acc ^ ((opc == crs_pkg::CRS_OP_LXOR) ? literal : file_rdata);
	wire [7:0]         swap_r    = {file_rdata[3:0], file_rdata[7:4]};
	wire is_sub  = take && (opc == crs_pkg::CRS_OP_LSUB || opc == crs_pkg::CRS_OP_FSUB);
	wire is_xor  = take && (opc == crs_pkg::CRS_OP_LXOR || opc == crs_pkg::CRS_OP_FXOR);
	wire is_swap = take && opc == crs_pkg::CRS_OP_SWAP;
	wire is_file = opc == crs_pkg::CRS_OP_FSUB || opc == crs_pkg::CRS_OP_FXOR
		|| opc == crs_pkg::CRS_OP_SWAP;
	wire [7:0]         result    = is_sub ? sub_r[7:0] : (is_xor ? xor_r : swap_r);
	wire               has_res   = is_sub || is_xor || is_swap;
	wire               to_file   = has_res && is_file && dest_sel == crs_pkg::DEST_FILE;
	wire               to_acc    = has_res && !to_file;

	//////////////////////////////////////////////////////////////////////////////
	// sequencer
	crs_pkg::crs_state_e next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			crs_pkg::CRS_ST_RUN: begin
				if (is_ret)
					next_state = crs_pkg::CRS_ST_REFILL;
				else if (is_sleep)
					next_state = crs_pkg::CRS_ST_SLEEP;
			end
			crs_pkg::CRS_ST_REFILL: next_state = crs_pkg::CRS_ST_RUN;
			crs_pkg::CRS_ST_SLEEP: begin
				if (wake)
					next_state = crs_pkg::CRS_ST_RUN;
			end
			default: next_state = crs_pkg::CRS_ST_RUN;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state        <= crs_pkg::CRS_ST_RUN;
			busy         <= 1'b0;
			fetch_refill <= 1'b0;
			osc_run      <= 1'b1;
		end else begin
			state        <= next_state;
			busy         <= next_state != crs_pkg::CRS_ST_RUN;
			fetch_refill <= next_state == crs_pkg::CRS_ST_REFILL;
			osc_run      <= next_state != crs_pkg::CRS_ST_SLEEP;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sp <= 3'h0;
			pc <= crs_pkg::PC_RESET;
		end else if (is_ret) begin
			sp <= sp_top;
			pc <= stack_top_entry;
		end else if (push_valid && state == crs_pkg::CRS_ST_RUN) begin
			stack_mem[sp] <= push_pc;
			sp            <= sp + 3'h1;
		end
	end

	// sleep side effects; watchdog otherwise free-runs
	always_ff @(posedge clock) begin
		if (rst) begin
			timeout_flag       <= crs_pkg::TMOUT_RESET;
			power_down_flag    <= crs_pkg::PWRDN_RESET;
			watchdog_counter   <= crs_pkg::WATCH_CLR;
			watchdog_prescaler <= crs_pkg::PRE_CLEARED;
		end else if (is_sleep) begin
			timeout_flag       <= 1'b1;
			power_down_flag    <= 1'b0;
			watchdog_counter   <= crs_pkg::WATCH_CLR;
			watchdog_prescaler <= crs_pkg::PRE_CLEARED;
		end else begin
			watchdog_prescaler <= watchdog_prescaler + 8'h01;
			if (watchdog_prescaler == 8'hff)
				watchdog_counter <= watchdog_counter + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			acc             <= crs_pkg::ACC_RESET;
			carry_flag      <= 1'b0;
			half_carry_flag <= 1'b0;
			zero_flag       <= 1'b0;
			file_we         <= 1'b0;
			file_waddr      <= 7'h00;
			file_wdata      <= 8'h00;
		end else begin
			file_we <= to_file;
			if (to_file) begin
				file_waddr <= file_addr;
				file_wdata <= result;
			end
			if (to_acc)
				acc <= result;
			if (is_sub) begin
				carry_flag      <= sub_r[9];
				half_carry_flag <= sub_r[8];
			end
			if (is_sub || is_xor)
				zero_flag <= result == 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ret_taken;
		is_ret;
	endsequence
	sequence s_refill_then_run;
		fetch_refill ##1 !fetch_refill;
	endsequence

	a_return_two_cycles: assert property (@(posedge clock) disable iff (rst)
		s_ret_taken |=> s_refill_then_run) else $error("return not two cycles");
	a_return_pc_load: assert property (@(posedge clock) disable iff (rst)
		is_ret |=> pc == $past(stack_top_entry) && $stable(zero_flag) && $stable(carry_flag))
		else $error("return pc or flags wrong");
	a_sleep_flags: assert property (@(posedge clock) disable iff (rst)
		is_sleep |=> timeout_flag && !power_down_flag && $stable(zero_flag))
		else $error("sleep flags wrong");
	a_sleep_watchdog: assert property (@(posedge clock) disable iff (rst)
		is_sleep |=> watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00)
		else $error("watchdog not cleared");
	a_sleep_osc_off: assert property (@(posedge clock) disable iff (rst)
		is_sleep ##1 !wake |=> !osc_run) else $error("oscillator not halted");
	a_lsub_result: assert property (@(posedge clock) disable iff (rst)
		take && opc == crs_pkg::CRS_OP_LSUB |=> acc == 8'($past(literal) - $past(acc))
		&& carry_flag == ($past(literal) >= $past(acc))) else $error("literal subtract wrong");
	a_fsub_carry: assert property (@(posedge clock) disable iff (rst)
		take && opc == crs_pkg::CRS_OP_FSUB |=> half_carry_flag ==
		($past(file_rdata[3:0]) >= $past(acc[3:0]))) else $error("half carry wrong");
	a_dest_file: assert property (@(posedge clock) disable iff (rst)
		to_file |=> file_we && file_waddr == $past(file_addr) && $stable(acc))
		else $error("file destination wrong");
	a_xor_zero_only: assert property (@(posedge clock) disable iff (rst)
		is_xor |=> $stable(carry_flag) && $stable(half_carry_flag)
		&& zero_flag == ($past(acc) == ($past(opc == crs_pkg::CRS_OP_LXOR) ? $past(literal)
		: $past(file_rdata)))) else $error("xor flags wrong");
	a_swap_no_flags: assert property (@(posedge clock) disable iff (rst)
		is_swap |=> $stable(zero_flag) && $stable(carry_flag)) else $error("swap touched flags");
	a_swap_to_acc: assert property (@(posedge clock) disable iff (rst)
		is_swap && dest_sel == 1'b0 |=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
		&& !file_we) else $error("swap to accumulator wrong");
endmodule // crs_core

// [verilog/crs_pkg.sv]
// crs_pkg: constants and types shared by the return/sleep/alu execution block
package crs_pkg;
	localparam int          DATA_W      = 8;
	localparam int          FADDR_W     = 7;
	localparam int          PC_W        = 13;
	localparam int          WATCH_W     = 8;
	localparam int          PRE_W       = 8;
	localparam int          STACK_DEPTH = 8;
	localparam int          SP_W        = 3;
	localparam int          RET_CYCLES  = 2;             // return takes two instruction cycles
	localparam logic [7:0]  WATCH_CLR   = 8'h00;         // watchdog value after sleep
	localparam logic [7:0]  PRE_CLEARED = 8'h00;         // prescaler value after sleep
	localparam logic [7:0]  ACC_RESET   = 8'h00;
	localparam logic [12:0] PC_RESET    = 13'h0000;
	localparam logic        TMOUT_RESET = 1'b1;
	localparam logic        PWRDN_RESET = 1'b1;
	localparam logic        DEST_ACC    = 1'b0;          // destination-select: accumulator
	localparam logic        DEST_FILE   = 1'b1;          // destination-select: file register

	// operation selector presented on the op port
	typedef enum logic [3:0] {
		CRS_OP_NONE   = 4'h0,
		CRS_OP_RETURN = 4'h1,
		CRS_OP_SLEEP  = 4'h2,
		CRS_OP_LSUB   = 4'h3,   // literal_minus_acc
		CRS_OP_FSUB   = 4'h4,   // file_minus_acc
		CRS_OP_LXOR   = 4'h5,   // literal_xor_acc
		CRS_OP_FXOR   = 4'h6,   // file_xor_acc
		CRS_OP_SWAP   = 4'h7    // nibble_exchange
	} crs_op_e;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		CRS_ST_RUN    = 3'b001,
		CRS_ST_REFILL = 3'b010,
		CRS_ST_SLEEP  = 3'b100
	} crs_state_e;
endpackage
